// [rtl/tmr_defines.svh]
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH

// Read pointers
`define TMR_RD_REMOTE_HIGH      8'h01
`define TMR_RD_STATUS           8'h02
`define TMR_RD_CONFIG           8'h03
`define TMR_RD_RATE             8'h04
`define TMR_RD_LOCAL_HIGH_LIMIT 8'h05
`define TMR_RD_REMOTE_LOW       8'h10
// Write pointers
`define TMR_WR_CONFIG           8'h09
`define TMR_WR_RATE             8'h0A
`define TMR_WR_LOCAL_HIGH_LIMIT 8'h0B
`define TMR_WR_ONE_SHOT         8'h0F
// Configuration fields
`define TMR_CFG_MASK_BIT        7
`define TMR_CFG_SHUTDOWN_BIT    6
`define TMR_CFG_PIN_SEL_BIT     5
`define TMR_CFG_RANGE_BIT       2
`define TMR_CFG_WR_MASK         8'hE4
`define TMR_CFG_RESET           8'h00
// Status fields
`define TMR_ST_OPEN_BIT         2
// Rate and limit
`define TMR_RATE_RESET          4'h8
`define TMR_RATE_MAX            4'h9
`define TMR_LHL_RESET           8'h55
`define TMR_REMOTE_RESET        8'h00
// Timing: idle tick equals fastest rate period
`define TMR_TICK_US             31250
`define TMR_CLK_MHZ             125
// Bus address, value arbitrary
`define TMR_SMB_ADDR            7'h4C

`endif

// [rtl/tmr_pkg.sv]
package tmr_pkg;
  typedef logic [7:0] tmr_byte_t;
  typedef enum logic {CV_IDLE, CV_RUN} tmr_conv_e;
  typedef enum logic [3:0] {
    SMB_IDLE, SMB_ADDR, SMB_ACK_ADDR, SMB_PTR, SMB_ACK_PTR,
    SMB_WDATA, SMB_ACK_W, SMB_RDATA, SMB_RACK
  } tmr_smb_e;
endpackage : tmr_pkg

// [rtl/tmr_smb_slave.sv]
`timescale 1ns/1ns
`include "tmr_defines.svh"
module tmr_smb_slave (
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  input  wire logic             i_scl,
  input  wire logic             i_sda,
  output logic                  o_sda_oe,
  output tmr_pkg::tmr_byte_t    o_ptr,
  output logic                  o_wr,
  output tmr_pkg::tmr_byte_t    o_wdata,
  output logic                  o_rd,
  input  wire tmr_pkg::tmr_byte_t i_rdata
);
  import tmr_pkg::*;

  logic [2:0] scl_q;
  logic [2:0] sda_q;
  tmr_smb_e   state_r;
  logic [3:0] cnt_r;
  tmr_byte_t  shreg_r;
  logic       rw_r;

  // Bit 0 is the metastable stage, only bit 1 reads it
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= {scl_q[1:0], i_scl};
      sda_q <= {sda_q[1:0], i_sda};
    end
  end

  wire scl_rise  = scl_q[1] & ~scl_q[2];
  wire scl_fall  = ~scl_q[1] & scl_q[2];
  wire scl_high  = scl_q[1] & scl_q[2];
  wire bus_start = scl_high & sda_q[2] & ~sda_q[1];
  wire bus_stop  = scl_high & ~sda_q[2] & sda_q[1];
  wire byte_done = (cnt_r == 4'h8);
  wire in_byte   = (state_r == SMB_ADDR) | (state_r == SMB_PTR) |
                   (state_r == SMB_WDATA) | (state_r == SMB_RDATA);

  always_ff @(posedge i_clk) begin
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    if (i_reset) begin
      state_r  <= SMB_IDLE;
      cnt_r    <= 4'h0;
      shreg_r  <= 8'h00;
      rw_r     <= 1'b0;
      o_sda_oe <= 1'b0;
      o_ptr    <= 8'h00;
      o_wdata  <= 8'h00;
    end else if (bus_start) begin
      state_r  <= SMB_ADDR;
      cnt_r    <= 4'h0;
      o_sda_oe <= 1'b0;
    end else if (bus_stop) begin
      state_r  <= SMB_IDLE;
      o_sda_oe <= 1'b0;
    end else if (scl_rise) begin
      // Master NACK ends the read
      if (state_r == SMB_RACK) begin
        if (sda_q[2]) state_r <= SMB_IDLE;
      end else if (in_byte) begin
        shreg_r <= {shreg_r[6:0], sda_q[2]};
        cnt_r   <= cnt_r + 4'h1;
      end
    end else if (scl_fall) begin
      unique case (state_r)
        SMB_IDLE: ;
        SMB_ADDR: if (byte_done) begin
          if (shreg_r[7:1] == `TMR_SMB_ADDR) begin
            rw_r     <= shreg_r[0];
            o_sda_oe <= 1'b1;
            state_r  <= SMB_ACK_ADDR;
          end else state_r <= SMB_IDLE;
        end
        SMB_ACK_ADDR: begin
          cnt_r <= 4'h0;
          if (rw_r) begin
            o_rd     <= 1'b1;
            shreg_r  <= i_rdata;
            o_sda_oe <= ~i_rdata[7];
            state_r  <= SMB_RDATA;
          end else begin
            o_sda_oe <= 1'b0;
            state_r  <= SMB_PTR;
          end
        end
        SMB_PTR: if (byte_done) begin
          o_ptr    <= shreg_r;
          o_sda_oe <= 1'b1;
          state_r  <= SMB_ACK_PTR;
        end
        SMB_WDATA: if (byte_done) begin
          o_wdata  <= shreg_r;
          o_wr     <= 1'b1;
          o_sda_oe <= 1'b1;
          state_r  <= SMB_ACK_W;
        end
        SMB_ACK_PTR, SMB_ACK_W: begin
          cnt_r    <= 4'h0;
          o_sda_oe <= 1'b0;
          state_r  <= SMB_WDATA;
        end
        SMB_RDATA: if (byte_done) begin
          o_sda_oe <= 1'b0;
          state_r  <= SMB_RACK;
        end else o_sda_oe <= ~shreg_r[7];
        SMB_RACK: begin
          cnt_r    <= 4'h0;
          o_rd     <= 1'b1;
          shreg_r  <= i_rdata;
          o_sda_oe <= ~i_rdata[7];
          state_r  <= SMB_RDATA;
        end
      endcase
    end
  end
endmodule : tmr_smb_slave

// [rtl/tmr_register_bank.sv]
`timescale 1ns/1ns
`include "tmr_defines.svh"
// Summary of operation
// - Remote high byte, 1 C, converter refreshed
// - High read first locks low byte
// - Low read first locks high byte
// - Reading any other register releases locks
// - Status bit 7 shows converter busy
// - Bits 6/5 local over/under limit
// - Bits 4/3 remote over/under limit
// - Bit 2 flags open remote junction
// - Bits 1/0 remote/local trip flags
// - Status read clears only absent conditions
// - Alert mode latches all flags
// - Second thermal mode latches only open
// - Config bit 7 masks alert output
// - Config bit 6 selects shutdown
// - Config bit 5 selects pin function
// - Config bit 2 selects extended range
// - Rate code low nibble, reset 1000b
// - Local high limit, 1 C weight
// - Rate code sets idle time only
// - Range bit only drives o_range_extended; converter sets result format
module tmr_register_bank #(
  parameter int TICK_CYCLES = `TMR_TICK_US * `TMR_CLK_MHZ
) (
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  input  wire logic             i_scl,
  input  wire logic             i_sda,
  output logic                  o_sda_oe,
  input  wire logic             i_conv_busy,
  input  wire logic             i_conv_done,
  input  wire tmr_pkg::tmr_byte_t i_remote_high,
  input  wire logic [3:0]       i_remote_low,
  input  wire tmr_pkg::tmr_byte_t i_local_temp,
  input  wire tmr_pkg::tmr_byte_t i_local_low_limit,
  input  wire tmr_pkg::tmr_byte_t i_remote_high_limit,
  input  wire tmr_pkg::tmr_byte_t i_remote_low_limit,
  input  wire logic             i_open_junction,
  input  wire logic             i_remote_trip,
  input  wire logic             i_local_trip,
  output logic                  o_conv_start,
  output logic                  o_shutdown_select,
  output logic                  o_range_extended,
  output logic                  o_multi_pin_n
);
  import tmr_pkg::*;

  tmr_byte_t  ptr;
  tmr_byte_t  wdata;
  tmr_byte_t  rdata;
  logic       wr;
  logic       rd;

  tmr_byte_t  remote_high_r;
  logic [3:0] remote_low_r;
  logic       lock_low_r;
  logic       lock_high_r;
  tmr_byte_t  cfg_r;
  logic [3:0] rate_r;
  tmr_byte_t  lhl_r;
  logic [6:0] cond_r;
  logic [6:0] flag_r;
  tmr_conv_e  conv_state_r;
  logic [21:0] tick_cnt_r;
  logic [9:0] idle_cnt_r;

  tmr_smb_slave u_smb (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_scl   (i_scl),
    .i_sda   (i_sda),
    .o_sda_oe(o_sda_oe),
    .o_ptr   (ptr),
    .o_wr    (wr),
    .o_wdata (wdata),
    .o_rd    (rd),
    .i_rdata (rdata)
  );

  // Address decode; RO pointers have no write strobe
  wire rd_high  = rd & (ptr == `TMR_RD_REMOTE_HIGH);
  wire rd_low   = rd & (ptr == `TMR_RD_REMOTE_LOW);
  wire st_rd    = rd & (ptr == `TMR_RD_STATUS);
  wire rd_other = rd & ~rd_high & ~rd_low;
  wire wr_cfg   = wr & (ptr == `TMR_WR_CONFIG);
  wire wr_rate  = wr & (ptr == `TMR_WR_RATE);
  wire wr_lhl   = wr & (ptr == `TMR_WR_LOCAL_HIGH_LIMIT);
  wire wr_shot  = wr & (ptr == `TMR_WR_ONE_SHOT);

  wire shutdown = cfg_r[`TMR_CFG_SHUTDOWN_BIT];
  wire pin_sel  = cfg_r[`TMR_CFG_PIN_SEL_BIT];
  wire mask     = cfg_r[`TMR_CFG_MASK_BIT];

  wire [7:0] status_byte = {i_conv_busy, flag_r};

  // Reserved bits read zero
  assign rdata =
    (ptr == `TMR_RD_REMOTE_HIGH)      ? remote_high_r :
    (ptr == `TMR_RD_STATUS)           ? status_byte :
    (ptr == `TMR_RD_CONFIG)           ? cfg_r :
    (ptr == `TMR_RD_RATE)             ? {4'h0, rate_r} :
    (ptr == `TMR_RD_LOCAL_HIGH_LIMIT) ? lhl_r :
    (ptr == `TMR_RD_REMOTE_LOW)       ? {remote_low_r, 4'h0} : 8'h00;

  wire lock_low_nxt  = rd_other ? 1'b0 :
                       rd_high  ? ~lock_high_r :
                       rd_low   ? 1'b0 : lock_low_r;
  wire lock_high_nxt = rd_other ? 1'b0 :
                       rd_low   ? ~lock_low_r :
                       rd_high  ? 1'b0 : lock_high_r;
  // Blocking on next lock keeps a same-cycle read coherent
  wire upd_high = i_conv_done & ~lock_high_nxt;
  wire upd_low  = i_conv_done & ~lock_low_nxt;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      lock_low_r  <= 1'b0;
      lock_high_r <= 1'b0;
    end else begin
      lock_low_r  <= lock_low_nxt;
      lock_high_r <= lock_high_nxt;
    end
  end

  // result capture; format arrives from converter
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      remote_high_r <= `TMR_REMOTE_RESET;
      remote_low_r  <= 4'h0;
    end else begin
      if (upd_high) remote_high_r <= i_remote_high;
      if (upd_low) remote_low_r <= i_remote_low;
    end
  end

  wire [6:0] cond_new = {
    i_local_temp > lhl_r,                 // local limits
    i_local_temp < i_local_low_limit,
    i_remote_high > i_remote_high_limit,  // remote limits
    i_remote_high < i_remote_low_limit,
    i_open_junction,                      // open junction
    i_remote_trip,                        // trip flags
    i_local_trip
  };
  wire [6:0] cond_nxt = i_conv_done ? cond_new : cond_r;
  wire [6:0] flag_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_flag
      wire latched = (gi == `TMR_ST_OPEN_BIT) | ~pin_sel;
      wire clr     = st_rd & ~cond_r[gi];
      assign flag_nxt[gi] = latched ?
        ((i_conv_done & cond_new[gi]) | (flag_r[gi] & ~clr)) : cond_nxt[gi];
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cond_r <= 7'h00;
      flag_r <= 7'h00;
    end else begin
      cond_r <= cond_nxt;
      flag_r <= flag_nxt;
    end
  end

  wire pin_nxt = pin_sel ? ~(cond_r[1] | cond_r[0]) : ~((|flag_r) & ~mask);

  always_ff @(posedge i_clk) begin
    if (i_reset) o_multi_pin_n <= 1'b1;
    else o_multi_pin_n <= pin_nxt;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cfg_r  <= `TMR_CFG_RESET;
      rate_r <= `TMR_RATE_RESET;
      lhl_r  <= `TMR_LHL_RESET;
    end else begin
      if (wr_cfg) cfg_r <= wdata & `TMR_CFG_WR_MASK;
      if (wr_rate) rate_r <= wdata[3:0];
      if (wr_lhl) lhl_r <= wdata;
    end
  end

  assign o_shutdown_select = shutdown;
  assign o_range_extended  = cfg_r[`TMR_CFG_RANGE_BIT];

  // Idle tick enable, one fastest-rate period
  wire tick = (tick_cnt_r == 22'(TICK_CYCLES - 1));

  always_ff @(posedge i_clk) begin
    if (i_reset || tick) tick_cnt_r <= 22'h000000;
    else tick_cnt_r <= tick_cnt_r + 22'h000001;
  end

  // idle length only; codes above max clamp
  wire [3:0] rate_clamp = (rate_r > `TMR_RATE_MAX) ? `TMR_RATE_MAX : rate_r;
  wire [3:0] rate_shift = `TMR_RATE_MAX - rate_clamp;
  wire [9:0] idle_load  = 10'h001 << rate_shift;
  wire       idle_over  = (idle_cnt_r == 10'h000);
  wire start_nxt = (conv_state_r == CV_IDLE) &
                   (shutdown ? wr_shot : idle_over);

  // Idle count starts at done; up to one tick of jitter
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      conv_state_r <= CV_IDLE;
      idle_cnt_r   <= 10'h000;
      o_conv_start <= 1'b0;
    end else begin
      o_conv_start <= start_nxt;
      if (start_nxt) conv_state_r <= CV_RUN;
      else if (i_conv_done && conv_state_r == CV_RUN) begin
        conv_state_r <= CV_IDLE;
        idle_cnt_r   <= idle_load;
      end else if (tick && !idle_over) idle_cnt_r <= idle_cnt_r - 10'h001;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  AST_HIGH_UPDATE:
    assert property (upd_high |=> remote_high_r == $past(i_remote_high))
    else $error("remote high byte not refreshed");

  AST_LOW_LOCKS:
    assert property (rd_high && !lock_high_r |=> lock_low_r)
    else $error("low byte lock not taken");

  AST_LOW_FROZEN:
    assert property (lock_low_r && !rd && i_conv_done |=> $stable(remote_low_r))
    else $error("low byte changed while locked");

  AST_HIGH_FROZEN:
    assert property (lock_high_r && !rd && i_conv_done |=> $stable(remote_high_r))
    else $error("high byte changed while locked");

  AST_OTHER_UNLOCK:
    assert property (rd_other |=> !lock_low_r && !lock_high_r)
    else $error("lock kept after other read");

  AST_BUSY_BIT:
    assert property (st_rd |-> rdata[7] == i_conv_busy)
    else $error("busy bit mismatch");

  AST_CLEAR_ON_READ:
    assert property (st_rd && !i_conv_done && !cond_r[6] |=> !flag_r[6])
    else $error("flag not cleared by status read");

  AST_ALERT_STICKY:
    assert property (!pin_sel && flag_r[4] && !st_rd ##1 !pin_sel |-> flag_r[4])
    else $error("alert mode flag dropped");

  AST_THERM2_FOLLOW:
    assert property (pin_sel && !wr_cfg |=> flag_r[6:3] == cond_r[6:3])
    else $error("second thermal mode flag latched");

  AST_SHUTDOWN_IDLE:
    assert property (shutdown && !wr_shot |=> !o_conv_start)
    else $error("start issued in shutdown");

  AST_IDLE_RELOAD:
    assert property (i_conv_done && conv_state_r == CV_RUN && !start_nxt
                     |=> idle_cnt_r == $past(idle_load))
    else $error("idle count not reloaded");

  AST_RO_WRITE:
    assert property (wr && ptr == `TMR_RD_REMOTE_HIGH && !i_conv_done
                     |=> $stable(remote_high_r) && $stable(lock_low_r))
    else $error("read-only write had effect");

  AST_HIGH_LOCKS:
    assert property (rd_low && !lock_low_r |=> lock_high_r)
    else $error("high byte lock not taken");

  AST_LOW_UNLOCK:
    assert property (rd_low |=> !lock_low_r)
    else $error("low byte lock kept after its read");

  AST_HIGH_UNLOCK:
    assert property (rd_high |=> !lock_high_r)
    else $error("high byte lock kept after its read");

  AST_LOW_UPDATE:
    assert property (upd_low |=> remote_low_r == $past(i_remote_low))
    else $error("remote low nibble not refreshed");

  AST_CFG_WRITE:
    assert property (wr_cfg |=> cfg_r == ($past(wdata) & `TMR_CFG_WR_MASK))
    else $error("configuration write lost");

  AST_RATE_WRITE:
    assert property (wr_rate |=> rate_r == $past(wdata[3:0]))
    else $error("rate code write lost");

  AST_LHL_WRITE:
    assert property (wr_lhl |=> lhl_r == $past(wdata))
    else $error("local high limit write lost");

  AST_LOCAL_OVER:
    assert property (i_conv_done && (i_local_temp > lhl_r) |=> flag_r[6])
    else $error("local over limit flag not set");

  AST_REMOTE_UNDER:
    assert property (i_conv_done && (i_remote_high < i_remote_low_limit) |=> flag_r[3])
    else $error("remote under limit flag not set");

  AST_OPEN_SET:
    assert property (i_conv_done && i_open_junction |=> flag_r[`TMR_ST_OPEN_BIT])
    else $error("open junction flag not set");

  AST_REMOTE_TRIP:
    assert property (i_conv_done && i_remote_trip |=> flag_r[1])
    else $error("remote trip flag not set");

  AST_OPEN_LATCH:
    assert property (pin_sel && flag_r[`TMR_ST_OPEN_BIT] && !st_rd |=> flag_r[`TMR_ST_OPEN_BIT])
    else $error("open junction flag dropped");

  AST_PIN_MASKED:
    assert property (!pin_sel && mask |=> o_multi_pin_n)
    else $error("masked alert output asserted");

  AST_PIN_THERM2:
    assert property (pin_sel && (cond_r[1] || cond_r[0]) |=> !o_multi_pin_n)
    else $error("second thermal output not asserted");

  AST_IDLE_WAIT:
    assert property (conv_state_r == CV_IDLE && !idle_over && !shutdown |=> !o_conv_start)
    else $error("start issued before idle time ran out");

  AST_STATUS_WRITE:
    assert property (wr && ptr == `TMR_RD_STATUS && !i_conv_done && !pin_sel
                     |=> $stable(flag_r))
    else $error("status write had effect");

endmodule : tmr_register_bank

// [testbench/tmr_smb_host.sv]
`timescale 1ns/1ns
`include "tmr_defines.svh"
// Host side of the two-wire bus; clock stands high between frames
module tmr_smb_host (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_oe
);
  import tmr_pkg::*;
  localparam int HALF = 8;
  logic nack_seen;
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
    nack_seen = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clk);
  endtask : wait_clk
  // Data moves two clocks after the clock falls, never beside it
  // Bit period 16 clocks, nearest the 125 ns target on this grid
  task automatic bit_io(input logic b, output logic s);
    o_sda_oe <= ~b;
    wait_clk(HALF - 2);
    o_scl <= 1'b1;
    wait_clk(HALF);
    s = i_sda;
    o_scl <= 1'b0;
    wait_clk(2);
  endtask : bit_io
  task automatic start_cond();
    o_sda_oe <= 1'b0;
    wait_clk(HALF);
    o_scl <= 1'b1;
    wait_clk(HALF);
    o_sda_oe <= 1'b1;
    wait_clk(HALF);
    o_scl <= 1'b0;
    wait_clk(2);
  endtask : start_cond
  task automatic stop_cond();
    o_sda_oe <= 1'b1;
    wait_clk(HALF);
    o_scl <= 1'b1;
    wait_clk(HALF);
    o_sda_oe <= 1'b0;
    wait_clk(HALF);
  endtask : stop_cond
  task automatic send_byte(input tmr_byte_t b, output logic nak);
    for (int i = 7; i >= 0; i--) bit_io(b[i], nak);
    bit_io(1'b1, nak);
  endtask : send_byte
  // Ends every read with a not-acknowledge, one byte a frame
  task automatic recv_byte(output tmr_byte_t b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(1'b1, s);
  endtask : recv_byte
  task automatic write_reg(input tmr_byte_t ptr, input tmr_byte_t val);
    logic a;
    start_cond();
    send_byte({`TMR_SMB_ADDR, 1'b0}, a);
    nack_seen = nack_seen | a;
    send_byte(ptr, a);
    send_byte(val, a);
    stop_cond();
  endtask : write_reg
  task automatic read_reg(input tmr_byte_t ptr, output tmr_byte_t val);
    logic a;
    start_cond();
    send_byte({`TMR_SMB_ADDR, 1'b0}, a);
    nack_seen = nack_seen | a;
    send_byte(ptr, a);
    start_cond();
    send_byte({`TMR_SMB_ADDR, 1'b1}, a);
    nack_seen = nack_seen | a;
    recv_byte(val);
    stop_cond();
  endtask : read_reg
endmodule : tmr_smb_host

// [testbench/testbench.sv]
`timescale 1ns/1ns
`include "tmr_defines.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD %s expected %h seen %h", nm, e, g); end end
module testbench;
  import tmr_pkg::*;
  localparam int TICK = 10;
  localparam int LIMIT = 60000;
  logic      i_clk, i_reset, scl, host_oe, dut_oe, busy, done, open_j, r_trip, l_trip;
  logic      conv_start, sd_sel, range_ext, multi_n;
  tmr_byte_t r_high, l_temp, l_low_lim, r_high_lim, r_low_lim, rd;
  logic [3:0] r_low;
  int        fail_count, checks, cycles, starts, s0;
  wire logic sda;
  // Open-drain data line with pull-up
  assign sda = ~(host_oe | dut_oe);
  tmr_register_bank #(.TICK_CYCLES(TICK)) dut (.i_clk(i_clk), .i_reset(i_reset),
    .i_scl(scl), .i_sda(sda), .o_sda_oe(dut_oe), .i_conv_busy(busy), .i_conv_done(done),
    .i_remote_high(r_high), .i_remote_low(r_low), .i_local_temp(l_temp),
    .i_local_low_limit(l_low_lim), .i_remote_high_limit(r_high_lim),
    .i_remote_low_limit(r_low_lim), .i_open_junction(open_j), .i_remote_trip(r_trip),
    .i_local_trip(l_trip), .o_conv_start(conv_start), .o_shutdown_select(sd_sel),
    .o_range_extended(range_ext), .o_multi_pin_n(multi_n));
  tmr_smb_host host (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(host_oe));
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (conv_start === 1'b1) starts <= starts + 1;
    if (cycles == LIMIT) begin
      fail_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  task automatic rd_chk(input string nm, input tmr_byte_t ptr, input tmr_byte_t e);
    host.read_reg(ptr, rd);
    `CHK(nm, e, rd)
  endtask : rd_chk
  task automatic conv(input tmr_byte_t rh, input logic [3:0] rl, input tmr_byte_t lt,
                      input logic [2:0] f);
    r_high <= rh;
    r_low <= rl;
    l_temp <= lt;
    {open_j, r_trip, l_trip} <= f;
    done <= 1'b1;
    @(posedge i_clk);
    done <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask : conv
  // Idle of k ticks, less up to one tick of phase
  task automatic gap(input logic [3:0] code, input int k);
    int n;
    host.write_reg(`TMR_WR_RATE, {4'h0, code});
    done <= 1'b1;
    @(posedge i_clk);
    done <= 1'b0;
    n = 0;
    while (conv_start !== 1'b1 && n < 200) begin
      @(posedge i_clk);
      n++;
    end
    `CHK("gap", 1'b1, (n >= (k - 1) * TICK && n <= k * TICK + 4))
  endtask : gap
  initial begin
    tmr_byte_t ptrs [6] = '{8'h03, 8'h04, 8'h05, 8'h01, 8'h10, 8'h20};
    tmr_byte_t vals [6] = '{8'h00, 8'h08, 8'h55, 8'h00, 8'h00, 8'h00};
    {fail_count, checks, cycles, starts} = '0;
    {busy, done, open_j, r_trip, l_trip, r_low, r_high, l_temp} = '0;
    l_low_lim = 8'h10;
    r_high_lim = 8'h70;
    r_low_lim = 8'h08;
    i_reset = 1'b1;
    repeat (6) @(posedge i_clk);
    i_reset <= 1'b0;
    repeat (3) @(posedge i_clk);
    for (int i = 0; i < 6; i++) rd_chk("reset", ptrs[i], vals[i]);
    busy <= 1'b1;
    rd_chk("busy", `TMR_RD_STATUS, 8'h80);
    busy <= 1'b0;
    rd_chk("idle", `TMR_RD_STATUS, 8'h00);
    gap(4'h9, 1);
    gap(4'h8, 2);
    gap(4'h7, 4);
    gap(4'hC, 1);
    host.write_reg(`TMR_WR_RATE, 8'h05);
    rd_chk("rate", `TMR_RD_RATE, 8'h05);
    host.write_reg(`TMR_WR_CONFIG, 8'h40);
    `CHK("sd", 1'b1, sd_sel)
    s0 = starts;
    conv(8'h00, 4'h0, 8'h20, 3'b000);
    repeat (80) @(posedge i_clk);
    `CHK("no start", s0, starts)
    host.write_reg(`TMR_WR_ONE_SHOT, 8'h00);
    `CHK("one shot", s0 + 1, starts)
    host.write_reg(`TMR_WR_CONFIG, 8'h44);
    `CHK("range", 1'b1, range_ext)
    rd_chk("cfg", `TMR_RD_CONFIG, 8'h44);
    host.write_reg(`TMR_WR_CONFIG, 8'h40);
    host.write_reg(`TMR_RD_REMOTE_HIGH, 8'hAA);
    rd_chk("ro", `TMR_RD_REMOTE_HIGH, 8'h00);
    host.write_reg(`TMR_WR_LOCAL_HIGH_LIMIT, 8'h30);
    rd_chk("lhl", `TMR_RD_LOCAL_HIGH_LIMIT, 8'h30);
    conv(8'h10, 4'h3, 8'h20, 3'b000);
    rd_chk("hi", `TMR_RD_REMOTE_HIGH, 8'h10);
    conv(8'h20, 4'h5, 8'h20, 3'b000);
    rd_chk("lo lock", `TMR_RD_REMOTE_LOW, 8'h30);
    rd_chk("cfg", `TMR_RD_CONFIG, 8'h40);
    conv(8'h30, 4'h7, 8'h20, 3'b000);
    rd_chk("lo", `TMR_RD_REMOTE_LOW, 8'h70);
    conv(8'h40, 4'h9, 8'h20, 3'b000);
    rd_chk("hi lock", `TMR_RD_REMOTE_HIGH, 8'h30);
    rd_chk("cfg", `TMR_RD_CONFIG, 8'h40);
    conv(8'h50, 4'hB, 8'h20, 3'b000);
    rd_chk("lo", `TMR_RD_REMOTE_LOW, 8'hB0);
    rd_chk("cfg", `TMR_RD_CONFIG, 8'h40);
    conv(8'h60, 4'hC, 8'h20, 3'b000);
    rd_chk("release", `TMR_RD_REMOTE_HIGH, 8'h60);
    // Under limit flags from the idle-gap results are still latched
    rd_chk("pre", `TMR_RD_STATUS, 8'h28);
    conv(8'h80, 4'h0, 8'h40, 3'b111);
    `CHK("alert", 1'b0, multi_n)
    rd_chk("st", `TMR_RD_STATUS, 8'h57);
    conv(8'h02, 4'h0, 8'h05, 3'b000);
    rd_chk("latch", `TMR_RD_STATUS, 8'h7F);
    rd_chk("clear", `TMR_RD_STATUS, 8'h28);
    host.write_reg(`TMR_WR_CONFIG, 8'hC0);
    `CHK("mask", 1'b1, multi_n)
    conv(8'h20, 4'h0, 8'h20, 3'b000);
    rd_chk("held", `TMR_RD_STATUS, 8'h28);
    rd_chk("gone", `TMR_RD_STATUS, 8'h00);
    host.write_reg(`TMR_WR_CONFIG, 8'h60);
    conv(8'h20, 4'h0, 8'h40, 3'b110);
    `CHK("therm2", 1'b0, multi_n)
    conv(8'h20, 4'h0, 8'h20, 3'b000);
    `CHK("therm2 off", 1'b1, multi_n)
    rd_chk("open", `TMR_RD_STATUS, 8'h04);
    rd_chk("open clr", `TMR_RD_STATUS, 8'h00);
    `CHK("ack", 1'b0, host.nack_seen)
    end_of_test();
  end
endmodule : testbench
